// [dv/epl_eeprom_model.sv]
`timescale 1ns/1ps
module epl_eeprom_model
  import epl_pkg::*;
(
  input  wire logic scl,
  input  wire logic sdaOeN,
  output logic      sdaWire
);
  logic [7:0]  mem [32768];
  logic [7:0]  sh;
  logic [14:0] addr;
  logic [3:0]  bitN;
  logic [1:0]  idx;
  logic        act;
  logic        rd;
  logic        rdCtl;
  logic        pull;
  logic [15:0] c;
  // pulled-up wire, low when either side pulls
  assign sdaWire = sdaOeN & ~pull;
  // pattern image, config part closed by its crc
  initial
  begin
    pull = 1'b0;
    act = 1'b0;
    rdCtl = 1'b0;
    c = CRC_INIT;
    for (int i = 0; i < 32768; i++)
      mem[i] = i[7:0] ^ 8'h3C;
    for (int i = 0; i < 2; i++)
      for (int b = 7; b >= 0; b--)
        c = (c[15] ^ mem[i][b]) ? {c[14:0], 1'b0} ^ CRC_POLY : {c[14:0], 1'b0};
    mem[2] = c[15:8];
    mem[3] = c[7:0];
  end
  // start opens a frame, stop closes it; the scl fall ending a start is no bit
  always @(sdaWire)
    if (scl === 1'b1)
    begin
      act = ~sdaWire;
      bitN = 4'hF;
      idx = 2'h0;
      rd = 1'b0;
      pull = 1'b0;
    end
  // sample master bits and its acknowledge
  always @(posedge scl)
    if (act)
      if (!rd && bitN < 4'h8)
        sh = {sh[6:0], sdaWire};
      else if (rd && bitN == 4'h8 && sdaWire)
        act = 1'b0;
  // drive acknowledge and read data while scl low
  always @(negedge scl)
    if (act)
    begin
      if (!rd && bitN == 4'h7)
      begin
        pull = (idx != 2'h0) || (sh[7:1] == {EE_DEV_HI, EE_DEV_LO});
        rdCtl = (idx == 2'h0) && sh[0] && pull;
        if (idx == 2'h1)
          addr[14:8] = sh[6:0];
        if (idx == 2'h2)
          addr[7:0] = sh;
        if (idx == 2'h3)
          mem[addr] = sh;
        if (idx == 2'h3)
          addr = addr + 15'h0001;
        else
          idx = idx + 2'h1;
      end
      else if (bitN == 4'h8 && (rd || rdCtl))
      begin
        rd = 1'b1;
        rdCtl = 1'b0;
        sh = mem[addr];
        addr = addr + 15'h0001;
        pull = ~sh[7];
      end
      else if (rd && bitN < 4'h7)
        pull = ~sh[4'h6 - bitN];
      else
        pull = 1'b0;
      bitN = (bitN == 4'h8) ? 4'h0 : bitN + 4'h1;
    end
endmodule : epl_eeprom_model

// [dv/epl_loader_monitor.sv]
`timescale 1ns/1ps
module epl_loader_monitor
  import epl_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYC
)
(
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic       regRdValid,
  input wire logic       ctrlReady,
  input wire logic       eepromScl,
  input wire logic       eepromSdaOut,
  input wire logic       eepromSdaOeN,
  input wire logic [7:0] bootData,
  input wire logic       bootValid,
  input wire logic       bootReady
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [19:0] hold;
  logic [5:0]  hiCnt;
  // cycles spent not ready, and scl high time
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hold <= 20'h0_0000;
      hiCnt <= 6'h00;
    end
    else
    begin
      hold <= ctrlReady ? 20'h0_0000 : hold + 20'h0_0001;
      hiCnt <= !eepromScl ? 6'h00 : (hiCnt == 6'h3F) ? hiCnt : hiCnt + 6'h01;
    end
  end
  // a taken reboot key write
  sequence reboot_s;
    regWrEn && ctrlReady && regAddr == ADDR_REBOOT && regWrData == REBOOT_KEY;
  endsequence
  sequence released_s;
    !ctrlReady && eepromScl && eepromSdaOeN;
  endsequence
  read_answer_a: assert property (regRdEn |=> regRdValid)
    else $error("read not answered");
  read_single_a: assert property (!regRdEn |=> !regRdValid)
    else $error("read answer without request");
  locked_read_a: assert property (regRdEn && !ctrlReady |=> regRdData == 8'h00)
    else $error("locked read gave data");
  holdoff_time_a: assert property ($rose(ctrlReady) |-> hold inside {[HOLD_CYCLES-2:HOLD_CYCLES+1]})
    else $error("holdoff length wrong");
  reboot_drop_a: assert property (reboot_s |-> ##[1:2] released_s)
    else $error("reboot did not reset");
  open_drain_a: assert property (!eepromSdaOeN |-> !eepromSdaOut)
    else $error("sda driven high");
  scl_high_a: assert property ($fell(eepromScl) |-> hiCnt inside {[23:25], 63})
    else $error("scl high time wrong");
  boot_hold_a: assert property (bootValid && !bootReady |=> bootValid && $stable(bootData))
    else $error("boot byte lost under stall");
endmodule : epl_loader_monitor

bind epl_loader epl_loader_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) u_epl_loader_monitor (
  .core_clk, .sys_rst, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .regRdValid,
  .ctrlReady, .eepromScl, .eepromSdaOut, .eepromSdaOeN, .bootData, .bootValid, .bootReady);

// [dv/epl_loader_test.sv]
`timescale 1ns/1ps
module epl_loader_test
  import epl_pkg::*;
();
  logic       core_clk, sys_rst, regWrEn, regRdEn, bootLoadSelect, bootReady;
  logic [7:0] regAddr, regWrData, regRdData, bootData, got;
  logic       regRdValid, ctrlReady, eepromScl, sdaOut, sdaOeN, sdaWire, bootValid;
  int         n_fail, comparisons;
  epl_loader #(.HOLD_CYCLES(200), .IMG_BYTES(40), .CONF_BYTES(4)) u_epl_loader (
    .core_clk, .sys_rst, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .regRdValid,
    .ctrlReady, .bootLoadSelect, .eepromScl, .eepromSdaIn(sdaWire), .eepromSdaOut(sdaOut),
    .eepromSdaOeN(sdaOeN), .bootData, .bootValid, .bootReady);
  epl_eeprom_model u_epl_eeprom_model (.scl(eepromScl), .sdaOeN, .sdaWire);
  // free-running clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge core_clk);
    regWrEn = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge core_clk);
    regRdEn = 1'b0;
    got = (regRdValid === 1'b1) ? regRdData : 8'hEE;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(got, e);
  endtask : rdc
  task automatic waitRdy();
    for (int i = 0; i < 1000 && ctrlReady !== 1'b1; i++)
      @(negedge core_clk);
  endtask : waitRdy
  task automatic waitEe();
    got = 8'h00;
    for (int i = 0; i < 20000 && got !== 8'h01; i++)
      rd(ADDR_EE_READY);
    chk(got, 8'h01);
  endtask : waitEe
  task automatic bootTest();
    int n;
    rdc(ADDR_PAGE_LO, 8'h00);
    waitRdy();
    rdc(ADDR_PAGE_HI, 8'h00);
    rdc(ADDR_COMMAND, 8'h00);
    repeat (18000) @(negedge core_clk);
    rdc(ADDR_REBOOT, 8'h00);
    rdc(ADDR_EE_READY, 8'h00);
    chk({7'h00, eepromScl}, 8'h00);
    bootReady = 1'b1;
    n = 0;
    for (int i = 0; i < 20000 && n < 40; i++)
    begin
      if (bootValid === 1'b1)
        chk(bootData, u_epl_eeprom_model.mem[n++]);
      @(negedge core_clk);
    end
    chk(n[7:0], 8'h28);
    waitEe();
    rdc(ADDR_REBOOT, 8'h01);
    rdc(ADDR_CHECKSUM, 8'h01);
  endtask : bootTest
  task automatic pageTest();
    wr(ADDR_BUF_PORT, 8'h77);
    wr(ADDR_COMMAND, CMD_PTR_RST);
    for (int i = 0; i < 64; i++)
      wr(ADDR_BUF_PORT, 8'hC0 ^ i[7:0]);
    wr(ADDR_PAGE_HI, 8'h41);
    wr(ADDR_PAGE_LO, 8'h40);
    rdc(ADDR_PAGE_HI, 8'h41);
    wr(ADDR_COMMAND, CMD_BURN);
    rdc(ADDR_EE_READY, 8'h00);
    waitEe();
    for (int i = 0; i < 64; i++)
      chk(u_epl_eeprom_model.mem[16'h4140 + i], 8'hC0 ^ i[7:0]);
    wr(ADDR_PAGE_HI, 8'h01);
    wr(ADDR_COMMAND, CMD_LOAD);
    waitEe();
    rdc(ADDR_COMMAND, 8'h01);
    wr(ADDR_COMMAND, CMD_PTR_RST);
    for (int i = 0; i < 64; i++)
      rdc(ADDR_BUF_PORT, u_epl_eeprom_model.mem[16'h0140 + i]);
    wr(ADDR_COMMAND, 8'h03);
    rdc(ADDR_EE_READY, 8'h01);
    rdc(8'hF5, 8'h00);
  endtask : pageTest
  task automatic softTest();
    bootLoadSelect = 1'b0;
    wr(ADDR_REBOOT, 8'h5A);
    chk({7'h00, ctrlReady}, 8'h01);
    wr(ADDR_REBOOT, REBOOT_KEY);
    @(negedge core_clk);
    chk({7'h00, ctrlReady}, 8'h00);
    rdc(ADDR_CHECKSUM, 8'h00);
    waitRdy();
    waitEe();
    rdc(ADDR_CHECKSUM, 8'h03);
    rdc(ADDR_PAGE_HI, 8'h00);
  endtask : softTest
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  // reset, then the scenarios
  initial
  begin
    n_fail = 0;
    comparisons = 0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    bootLoadSelect = 1'b1;
    bootReady = 1'b0;
    sys_rst = 1'b1;
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    bootTest();
    pageTest();
    softTest();
    conclude();
  end
  // watchdog against a hung handshake
  initial
  begin
    repeat (95000) @(posedge core_clk);
    n_fail++;
    conclude();
  end
endmodule : epl_loader_test

// [inc/epl_pkg.sv]
package epl_pkg;

  // clock and link timing
  localparam int CLK_KHZ  = 50000;
  localparam int LINK_KHZ = 1000;
  localparam int BIT_CYC  = CLK_KHZ / LINK_KHZ;
  localparam int QTR_CYC  = (BIT_CYC / 4 < 1) ? 1 : BIT_CYC / 4;
  localparam int HOLD_MS  = 10;
  localparam int HOLD_CYC = HOLD_MS * CLK_KHZ;
  localparam int OTP_CYC  = 64;

  // image and page geometry
  localparam int IMAGE_BYTES = 18048;
  localparam int CFG_BYTES   = 1024;
  localparam int PAGE_BYTES  = 64;
  localparam int PAGE_LSB    = 6;
  localparam int PAGE_MSB    = 14;
  localparam int RETRY_MAX   = 255;
  localparam int FIFO_WIDTH  = 8;
  localparam int FIFO_DEPTH  = 32;

  // register offsets
  localparam logic [7:0] ADDR_EE_READY = 8'hF0;
  localparam logic [7:0] ADDR_PAGE_HI  = 8'hF1;
  localparam logic [7:0] ADDR_PAGE_LO  = 8'hF2;
  localparam logic [7:0] ADDR_BUF_PORT = 8'hF3;
  localparam logic [7:0] ADDR_COMMAND  = 8'hF4;
  localparam logic [7:0] ADDR_REBOOT   = 8'hF8;
  localparam logic [7:0] ADDR_CHECKSUM = 8'hF9;

  // values and reset values
  localparam logic [7:0]  REBOOT_KEY  = 8'hA5;
  localparam logic [1:0]  CMD_PTR_RST = 2'h0;
  localparam logic [1:0]  CMD_LOAD    = 2'h1;
  localparam logic [1:0]  CMD_BURN    = 2'h2;
  localparam logic [1:0]  CMD_RST     = 2'h0;
  localparam logic [15:0] PAGE_RST    = 16'h0000;
  localparam logic [3:0]  EE_DEV_HI   = 4'hA;
  localparam logic [2:0]  EE_DEV_LO   = 3'h0;
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [15:0] CRC_INIT    = 16'hFFFF;

  typedef enum logic [1:0] {LK_IDLE, LK_START, LK_BYTE, LK_STOP} eplLinkSt_t;
  typedef enum logic [2:0] {SQ_CTLW, SQ_AHI, SQ_ALO, SQ_RSTART, SQ_CTLR, SQ_DATA} eplSeq_t;
  typedef enum logic [1:0] {OP_NONE, OP_BOOT, OP_LOAD, OP_BURN} eplOp_t;
  typedef enum logic [1:0] {BT_OTP, BT_EEPROM, BT_DONE} eplBoot_t;

  typedef struct packed {
    eplLinkSt_t                     linkSt;
    eplSeq_t                        seq;
    eplOp_t                         op;
    eplBoot_t                       bootSt;
    logic                           sdaMeta;
    logic                           sdaIn;
    logic                           selMeta;
    logic                           selIn;
    logic [19:0]                    holdCnt;
    logic                           ctrlReady;
    logic [7:0]                     otpCnt;
    logic [5:0]                     divCnt;
    logic [1:0]                     phase;
    logic [3:0]                     bitIdx;
    logic [7:0]                     shift;
    logic                           nack;
    logic                           retry;
    logic [7:0]                     retryCnt;
    logic [14:0]                    byteCnt;
    logic [15:0]                    crc;
    logic [1:0]                     crcRes;
    logic                           scl;
    logic                           sda;
    logic                           pushValid;
    logic [7:0]                     pushData;
    logic [15:0]                    pageSel;
    logic [1:0]                     cmd;
    logic [5:0]                     ptr;
    logic [PAGE_BYTES-1:0][7:0]     pageBuf;
    logic                           rdValid;
    logic [7:0]                     rdData;
  } eplState_t;

endpackage : epl_pkg

// [rtl/epl_loader.sv]
// Functional notes
// R1 - The page select register picks one 64-byte page of the 9-bit page space for the next load or burn.
// R2 - Software puts the page in bits 14:6 and zeros in bit 15 and bits 5:0 of the page select register.
// R3 - The 8-bit buffer port moves one byte of the 64-byte page buffer per access and advances the pointer.
// R4 - Command 0 returns the buffer pointer to the first byte.
// R5 - Command 1 reads the selected EEPROM page into the page buffer.
// R6 - Command 2 programs the page buffer into the selected EEPROM page.
// R7 - Writing 0xA5 to the reboot register performs a soft reset.
// R8 - Checksum bit 0 reads 1 when the configuration image passed and 0 when it failed.
// R9 - Checksum bit 1 reads 1 when the code image passed and 0 when it failed.
// R10 - With the boot-load select input high the device loads its image from the EEPROM over the serial pins.
// R11 - On reboot the internal content loads first and the EEPROM image follows only if the select input is high.
// R12 - After a soft reset the registers become reachable again after 10 ms.
// R13 - The EEPROM is addressed with a device address whose low three bits are 000.
// R14 - The serial link to the EEPROM runs at 1 MHz; the code takes 48 cycles of the 50 MHz clock per bit.
// R15 - The EEPROM ready bit reads 0 during a load or burn and 1 when a new command may be issued.
// R16 - The boot load done bit reads 0 until the boot-time load completes and 1 afterwards.
`timescale 1ns/1ps

module epl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [AW:0]                 count;
    logic                        outValid;
    logic [WIDTH-1:0]            outData;
  } eplFifoState_t;

  eplFifoState_t r;
  eplFifoState_t next_r;
  logic          push;
  logic          load;

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_bad_fifo
    $error("fifo depth must be a power of two of at least 2");
  end

  // honest full: ready only while a memory slot is free
  assign inReady  = (r.count != (AW+1)'(DEPTH));
  assign outValid = r.outValid;
  assign outData  = r.outData;

  // memory plus a registered output word
  always_comb
  begin
    next_r = r;
    push   = inValid && inReady;
    load   = (!r.outValid || outReady) && (r.count != '0);
    if (r.outValid && outReady)
      next_r.outValid = 1'b0;
    if (load)
    begin
      next_r.outData  = r.mem[r.rdPtr];
      next_r.outValid = 1'b1;
      next_r.rdPtr    = r.rdPtr + AW'(1);
    end
    if (push)
    begin
      next_r.mem[r.wrPtr] = inData;
      next_r.wrPtr        = r.wrPtr + AW'(1);
    end
    next_r.count = r.count + (AW+1)'(push) - (AW+1)'(load);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      r <= '0;
    else
      r <= next_r;
  end

endmodule : epl_fifo

module epl_loader
  import epl_pkg::*;
#(
  parameter int         HOLD_CYCLES = HOLD_CYC,
  parameter int         IMG_BYTES   = IMAGE_BYTES,
  parameter int         CONF_BYTES  = CFG_BYTES,
  parameter logic [3:0] DEV_ADDR_HI = EE_DEV_HI
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic [7:0]      regRdData,
  output logic            regRdValid,
  output logic            ctrlReady,
  input  wire logic       bootLoadSelect,
  output logic            eepromScl,
  input  wire logic       eepromSdaIn,
  output logic            eepromSdaOut,
  output logic            eepromSdaOeN,
  output logic [7:0]      bootData,
  output logic            bootValid,
  input  wire logic       bootReady
);
  localparam logic [19:0] HOLD_LAST  = 20'(HOLD_CYCLES - 1);
  localparam logic [7:0]  OTP_LAST   = 8'(OTP_CYC - 1);
  localparam logic [5:0]  QTR_LAST   = 6'(QTR_CYC - 1);
  localparam logic [14:0] IMG_LAST   = 15'(IMG_BYTES - 1);
  localparam logic [14:0] CONF_LAST  = 15'(CONF_BYTES - 1);
  localparam logic [14:0] PAGE_LAST  = 15'(PAGE_BYTES - 1);
  localparam logic [7:0]  RETRY_LAST = 8'(RETRY_MAX);

  localparam eplState_t RST_VAL = '{linkSt: LK_IDLE, seq: SQ_CTLW, op: OP_NONE, bootSt: BT_OTP,
                                    scl: 1'b1, sda: 1'b1, crc: CRC_INIT, pageSel: PAGE_RST,
                                    cmd: CMD_RST, default: '0};

  eplState_t   r;
  eplState_t   next_r;
  logic        tick;
  logic        rx;
  logic        lastByte;
  logic        idle;
  logic        fifoInReady;
  logic [15:0] crcNext;
  logic [15:0] eeAddr;
  logic [7:0]  ctlByte;

  if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (1 << 20) || CONF_BYTES < 1 || IMG_BYTES <= CONF_BYTES
      || IMG_BYTES >= (1 << 15))
  begin : g_bad_param
    $error("loader counts out of range");
  end

  // crc16 of one byte, msb first
  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++)
      x = x[15] ? ((x << 1) ^ CRC_POLY) : (x << 1);
    return x;
  endfunction : crcByte

  // boot image stream to the user side; full fifo stalls the link
  epl_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (core_clk),
    .rst      (sys_rst),
    .inValid  (r.pushValid),
    .inData   (r.pushData),
    .inReady  (fifoInReady),
    .outValid (bootValid),
    .outData  (bootData),
    .outReady (bootReady)
  );

  assign regRdData    = r.rdData;
  assign regRdValid   = r.rdValid;
  assign ctrlReady    = r.ctrlReady;
  assign eepromScl    = r.scl;
  assign eepromSdaOut = r.sda;
  // open drain: driven only while low
  assign eepromSdaOeN = r.sda;

  always_comb
  begin
    next_r   = r;
    tick     = 1'b0;
    idle     = (r.op == OP_NONE) && (r.bootSt == BT_DONE);
    rx       = (r.seq == SQ_DATA) && (r.op != OP_BURN);
    lastByte = (r.op == OP_BOOT) ? (r.byteCnt == IMG_LAST) : (r.byteCnt == PAGE_LAST);
    crcNext  = crcByte(r.crc, r.shift);
    // R1 page to byte address
    eeAddr   = (r.op == OP_BOOT) ? 16'h0000 : {1'b0, r.pageSel[PAGE_MSB:PAGE_LSB], 6'h00};
    // R13 device address low bits
    ctlByte  = {DEV_ADDR_HI, EE_DEV_LO, 1'b0};
    next_r.rdValid   = 1'b0;
    next_r.pushValid = 1'b0;

    // two-stage synchronisers
    next_r.sdaMeta = eepromSdaIn;
    next_r.sdaIn   = r.sdaMeta;
    next_r.selMeta = bootLoadSelect;
    next_r.selIn   = r.selMeta;

    // R12 register holdoff after any reset
    if (!r.ctrlReady)
    begin
      if (r.holdCnt == HOLD_LAST)
        next_r.ctrlReady = 1'b1;
      else
        next_r.holdCnt = r.holdCnt + 20'd1;
    end

    // R11 internal content first, then optional eeprom image
    if (r.bootSt == BT_OTP)
    begin
      if (r.otpCnt != OTP_LAST)
        next_r.otpCnt = r.otpCnt + 8'd1;
      // R10 select input picks eeprom boot
      else if (r.selIn)
      begin
        next_r.bootSt = BT_EEPROM;
        next_r.op     = OP_BOOT;
        next_r.linkSt = LK_START;
        next_r.seq    = SQ_CTLW;
      end
      else
      begin
        next_r.bootSt = BT_DONE;
        next_r.crcRes = 2'b11;
      end
    end

    // R14 quarter-bit divider
    if (r.linkSt != LK_IDLE)
    begin
      if (r.divCnt == QTR_LAST)
      begin
        next_r.divCnt = '0;
        tick          = 1'b1;
      end
      else
        next_r.divCnt = r.divCnt + 6'd1;
    end

    // link bit engine
    if (tick)
    begin
      unique case (r.linkSt)
        LK_IDLE:
          next_r.phase = '0;
        LK_START:
        begin
          next_r.phase = r.phase + 2'd1;
          unique case (r.phase)
            2'd0: next_r.sda = 1'b1;
            2'd1: next_r.scl = 1'b1;
            2'd2: next_r.sda = 1'b0;
            2'd3:
            begin
              next_r.scl    = 1'b0;
              next_r.linkSt = LK_BYTE;
              next_r.bitIdx = '0;
              next_r.seq    = (r.seq == SQ_RSTART) ? SQ_CTLR : SQ_CTLW;
              next_r.shift  = {ctlByte[7:1], r.seq == SQ_RSTART};
            end
          endcase
        end
        LK_BYTE:
        begin
          // hold scl low before a boot byte while the fifo has no room
          if (!(r.phase == 2'd0 && r.bitIdx == 4'd0 && rx && r.op == OP_BOOT
                && (!fifoInReady || r.pushValid)))
          begin
            next_r.phase = r.phase + 2'd1;
            unique case (r.phase)
              2'd0: next_r.sda = (r.bitIdx == 4'd8) ? (rx ? lastByte : 1'b1) : (rx ? 1'b1 : r.shift[7]);
              2'd1: next_r.scl = 1'b1;
              2'd2:
              begin
                if (r.bitIdx == 4'd8)
                  next_r.nack = r.sdaIn;
                else
                  next_r.shift = {r.shift[6:0], r.sdaIn};
              end
              2'd3:
              begin
                next_r.scl = 1'b0;
                if (r.bitIdx != 4'd8)
                  next_r.bitIdx = r.bitIdx + 4'd1;
                else
                begin
                  next_r.bitIdx = '0;
                  next_r.retry  = 1'b0;
                  unique case (r.seq)
                    SQ_CTLW:
                    begin
                      if (r.nack)
                      begin
                        // eeprom busy writing: poll again
                        next_r.linkSt   = LK_STOP;
                        next_r.retry    = (r.retryCnt != RETRY_LAST);
                        next_r.retryCnt = r.retryCnt + 8'd1;
                      end
                      else
                      begin
                        next_r.seq   = SQ_AHI;
                        next_r.shift = eeAddr[15:8];
                      end
                    end
                    SQ_AHI:
                    begin
                      next_r.seq   = SQ_ALO;
                      next_r.shift = eeAddr[7:0];
                      if (r.nack)
                        next_r.linkSt = LK_STOP;
                    end
                    SQ_ALO:
                    begin
                      if (r.nack)
                        next_r.linkSt = LK_STOP;
                      // R6 burn streams the buffer
                      else if (r.op == OP_BURN)
                      begin
                        next_r.seq     = SQ_DATA;
                        next_r.byteCnt = '0;
                        next_r.shift   = r.pageBuf[0];
                      end
                      else
                      begin
                        next_r.seq    = SQ_RSTART;
                        next_r.linkSt = LK_START;
                      end
                    end
                    SQ_RSTART:
                      next_r.linkSt = LK_STOP;
                    SQ_CTLR:
                    begin
                      next_r.seq     = SQ_DATA;
                      next_r.byteCnt = '0;
                      if (r.nack)
                        next_r.linkSt = LK_STOP;
                    end
                    SQ_DATA:
                    begin
                      if (r.op == OP_BURN)
                      begin
                        next_r.byteCnt = r.byteCnt + 15'd1;
                        next_r.shift   = r.pageBuf[6'(r.byteCnt + 15'd1)];
                      end
                      // R5 load fills the buffer
                      else if (r.op == OP_LOAD)
                      begin
                        next_r.pageBuf[6'(r.byteCnt)] = r.shift;
                        next_r.byteCnt                = r.byteCnt + 15'd1;
                      end
                      else
                      begin
                        next_r.pushValid = 1'b1;
                        next_r.pushData  = r.shift;
                        next_r.crc       = crcNext;
                        next_r.byteCnt   = r.byteCnt + 15'd1;
                        // R8 config section checksum
                        if (r.byteCnt == CONF_LAST)
                        begin
                          next_r.crcRes[0] = (crcNext == 16'h0000);
                          next_r.crc       = CRC_INIT;
                        end
                        // R9 code section checksum
                        if (lastByte)
                          next_r.crcRes[1] = (crcNext == 16'h0000);
                      end
                      if (lastByte || (r.op == OP_BURN && r.nack))
                        next_r.linkSt = LK_STOP;
                    end
                  endcase
                end
              end
            endcase
          end
        end
        LK_STOP:
        begin
          next_r.phase = r.phase + 2'd1;
          unique case (r.phase)
            2'd0: next_r.sda = 1'b0;
            2'd1: next_r.scl = 1'b1;
            2'd2: next_r.sda = 1'b1;
            2'd3:
            begin
              next_r.linkSt = r.retry ? LK_START : LK_IDLE;
              next_r.seq    = SQ_CTLW;
              if (!r.retry)
              begin
                // R16 boot load complete
                if (r.op == OP_BOOT)
                  next_r.bootSt = BT_DONE;
                next_r.op = OP_NONE;
              end
            end
          endcase
        end
      endcase
    end

    // register reads: one cycle latency, zero while held off
    if (regRdEn)
    begin
      next_r.rdValid = 1'b1;
      next_r.rdData  = 8'h00;
      if (r.ctrlReady)
      begin
        case (regAddr)
          // R15 ready bit
          ADDR_EE_READY: next_r.rdData = {7'h00, idle};
          ADDR_PAGE_HI:  next_r.rdData = r.pageSel[15:8];
          ADDR_PAGE_LO:  next_r.rdData = r.pageSel[7:0];
          ADDR_COMMAND:  next_r.rdData = {6'h00, r.cmd};
          ADDR_REBOOT:   next_r.rdData = {7'h00, r.bootSt == BT_DONE};
          ADDR_CHECKSUM: next_r.rdData = {6'h00, r.crcRes};
          ADDR_BUF_PORT:
          begin
            // R3 buffer read advances pointer
            if (idle)
            begin
              next_r.rdData = r.pageBuf[r.ptr];
              next_r.ptr    = r.ptr + 6'd1;
            end
          end
          default:       next_r.rdData = 8'h00;
        endcase
      end
    end

    // register writes
    if (regWrEn && r.ctrlReady)
    begin
      case (regAddr)
        // R2 page field placement
        ADDR_PAGE_HI: next_r.pageSel[15:8] = regWrData;
        ADDR_PAGE_LO: next_r.pageSel[7:0]  = regWrData;
        ADDR_BUF_PORT:
        begin
          // R3 buffer write advances pointer
          if (idle)
          begin
            next_r.pageBuf[r.ptr] = regWrData;
            next_r.ptr            = r.ptr + 6'd1;
          end
        end
        ADDR_COMMAND:
        begin
          next_r.cmd = regWrData[1:0];
          if (idle)
          begin
            next_r.retryCnt = '0;
            next_r.seq      = SQ_CTLW;
            // R4 pointer rewind
            if (regWrData[1:0] == CMD_PTR_RST)
              next_r.ptr = '0;
            else if (regWrData[1:0] == CMD_LOAD || regWrData[1:0] == CMD_BURN)
            begin
              next_r.op     = (regWrData[1:0] == CMD_LOAD) ? OP_LOAD : OP_BURN;
              next_r.linkSt = LK_START;
            end
          end
        end
        ADDR_REBOOT:
        begin
          // R7 soft reset key
          if (regWrData == REBOOT_KEY)
          begin
            next_r         = RST_VAL;
            next_r.sdaMeta = eepromSdaIn;
            next_r.sdaIn   = r.sdaMeta;
            next_r.selMeta = bootLoadSelect;
            next_r.selIn   = r.selMeta;
          end
        end
        default: next_r.ptr = next_r.ptr;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      r <= RST_VAL;
    else
      r <= next_r;
  end

endmodule : epl_loader
